// ==== core/remote_digit_programming_port.sv ====
// Purpose: Listener on an eight-line instrument bus feeding digit registers
// Assumes: All bus pins asynchronous; settle-busy and load-ready on i_sys_clk
// Notes:   Accepted data bytes pass a FIFO before the digit engine
//
// Behaviour
// - Listener shifts received digits in at the most significant end.
// - Address code copies temporary register into the selected final register.
// - Temporary register clears to zero right after each transfer.
// - First digit 15 marks an address; second digit selects register.
// - Address 1 loads the step increment register.
// - Address 5 loads modulation percent, address 4 modulation function.
// - All-zero modulation function disables all modulation.
// - Source digit: 1 int 1 kHz, 2 int 400 Hz, 4 ext DC, 9 ext AC.
// - Percent scales full range; FM x10 full scale is 1000 kHz.
// - Listen address makes a listener until unlisten arrives.
// - Mode line low: addresses and commands; high: data.
// - Ready-for-byte released high only when ready to accept.
// - After DAV falls: pull ready low, capture, release byte-accepted.
// - When DAV rises, byte-accepted goes low again.
// - Remote entered when REN low and addressed; left when REN high.
// - Bus abort drops addressing and stops all bus activity.
// - Service-request and EOI lines are never driven.
// - Jumper fitted: hold ready-for-byte low while settling is pending.
// - Bus lines are ground-true: low means logic one.
// - Attenuator keeps only the three most significant digits.
// - Reset clears control state and all data registers except the FIFO memory.
`timescale 1ns/1ns
`default_nettype none

module digit_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 32
) (
    // Clock and reset
    input  wire logic             i_sys_clk,
    input  wire logic             i_reset_n,
    input  wire logic             i_clk_en,
    // Fill side
    input  wire logic             i_in_valid,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_in_ready,
    // Drain side
    output logic                  o_out_valid,
    output logic [WIDTH-1:0]      o_out_data,
    input  wire logic             i_out_ready
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_q;
    logic [AW:0]      rd_q;
    wire              push = i_in_valid && o_in_ready;
    wire              pop  = o_out_valid && i_out_ready;

    assign o_in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
    assign o_out_valid = wr_q != rd_q;
    assign o_out_data  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge i_sys_clk) begin
        if (i_clk_en && push) begin
            mem_q[wr_q[AW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            wr_q <= '0;
            rd_q <= '0;
        end else if (i_clk_en) begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop)  rd_q <= rd_q + 1'b1;
        end
    end
endmodule : digit_fifo

module remote_digit_programming_port (
    // Clock, reset, enable
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_reset_n,
    input  wire logic                    i_clk_en,
    // Bus pins, asynchronous
    input  wire logic [7:0]              i_bus_data_pin,
    input  wire logic                    i_dav_n,
    input  wire logic                    i_address_data_select,
    input  wire logic                    i_ren_n,
    input  wire logic                    i_bus_abort_line_n,
    input  wire logic                    i_rfd_delay_jumper,
    // Open-drain handshake drives
    output logic                         o_ready_for_byte_o,
    output logic                         o_ready_for_byte_oe,
    output logic                         o_dac_o,
    output logic                         o_dac_oe,
    output logic                         o_srq_oe,
    output logic                         o_eoi_oe,
    // Instrument side
    input  wire logic                    i_settle_busy,
    input  wire logic                    i_load_ready,
    output logic                         o_listen,
    output logic                         o_local_remote_indicator,
    output logic [rdp_pkg::TEMP_W-1:0]   o_temp_digits,
    output logic [rdp_pkg::TEMP_W-1:0]   o_center_freq,
    output logic [rdp_pkg::TEMP_W-1:0]   o_step_increment_register,
    output logic [rdp_pkg::ATTEN_W-1:0]  o_attenuator,
    output logic [7:0]                   o_mod_function,
    output logic [7:0]                   o_mod_percent,
    output logic                         o_mod_enable,
    output rdp_pkg::mod_type_e           o_mod_type,
    output rdp_pkg::mod_src_e            o_mod_source,
    output logic [9:0]                   o_mod_depth
);
    import rdp_pkg::*;

    // -------------------------------------------------------------------
    // Synchronisers
    // -------------------------------------------------------------------
    logic [SYNC_W-1:0] s1_q;
    logic [SYNC_W-1:0] s2_q;
    logic              dav_prev_q;
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            s1_q       <= '1;
            s2_q       <= '1;
            dav_prev_q <= 1'b1;
        end else if (i_clk_en) begin
            s1_q       <= {i_bus_data_pin, i_dav_n, i_address_data_select,
                           i_ren_n, i_bus_abort_line_n, i_rfd_delay_jumper};
            s2_q       <= s1_q;
            dav_prev_q <= s2_q[4];
        end
    end

    wire [7:0] bus_byte  = ~s2_q[12:5];
    wire       dav_n_s   = s2_q[4];
    wire       data_mode = s2_q[3];
    wire       ren_n_s   = s2_q[2];
    wire       abort     = !s2_q[1];
    wire       jumper    = !s2_q[0];
    wire       dav_fall  = dav_prev_q && !dav_n_s;

    // -------------------------------------------------------------------
    // Three-wire handshake
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {HS_IDLE, HS_ACCEPT, HS_DONE} hs_e;
    hs_e        hs_q;
    hs_e        hs_d;
    logic [7:0] byte_q;
    logic       mode_q;
    logic       listen_q;
    logic       listen_d;
    logic       remote_q;
    logic       fifo_in_ready;

    wire active   = !data_mode || listen_q;
    wire rfd_ok   = fifo_in_ready && !(jumper && i_settle_busy);
    wire take     = hs_q == HS_IDLE && dav_fall && active && !o_ready_for_byte_oe;
    wire push     = hs_q == HS_ACCEPT && mode_q;
    wire cmd      = hs_q == HS_ACCEPT && !mode_q;

    always_comb begin
        hs_d = hs_q;
        case (hs_q)
            HS_IDLE:   if (take) hs_d = HS_ACCEPT;
            HS_ACCEPT: hs_d = HS_DONE;
            HS_DONE:   if (dav_n_s) hs_d = HS_IDLE;
            default:   hs_d = HS_IDLE;
        endcase
        if (abort) hs_d = HS_IDLE;
    end

    always_comb begin
        listen_d = listen_q;
        if (cmd && byte_q == LISTEN_ADDR) listen_d = 1'b1;
        if (cmd && byte_q == UNLISTEN_CMD) listen_d = 1'b0;
        if (abort) listen_d = 1'b0;
    end

    wire rfd_oe_d = active && !abort && !(hs_d == HS_IDLE && rfd_ok);
    wire dac_oe_d = active && !abort && hs_d != HS_DONE;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hs_q                <= HS_IDLE;
            byte_q              <= BYTE_RESET;
            mode_q              <= 1'b0;
            listen_q            <= 1'b0;
            remote_q            <= 1'b0;
            o_ready_for_byte_oe <= 1'b0;
            o_dac_oe            <= 1'b0;
        end else if (i_clk_en) begin
            hs_q                <= hs_d;
            listen_q            <= listen_d;
            o_ready_for_byte_oe <= rfd_oe_d;
            o_dac_oe            <= dac_oe_d;
            if (take) begin
                byte_q <= bus_byte;
                mode_q <= data_mode;
            end
            if (ren_n_s) remote_q <= 1'b0;
            else if (listen_d) remote_q <= 1'b1;
        end
    end

    // -------------------------------------------------------------------
    // Entry buffer
    // -------------------------------------------------------------------
    logic   fifo_out_valid;
    entry_s head;
    wire    head_is_addr  = head.d1 == ADDR_MARK;
    wire    fifo_out_rdy  = !head_is_addr || i_load_ready;
    wire    pop           = fifo_out_valid && fifo_out_rdy;

    digit_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .i_sys_clk   (i_sys_clk),
        .i_reset_n   (i_reset_n),
        .i_clk_en    (i_clk_en),
        .i_in_valid  (push),
        .i_in_data   (byte_q),
        .o_in_ready  (fifo_in_ready),
        .o_out_valid (fifo_out_valid),
        .o_out_data  (head),
        .i_out_ready (fifo_out_rdy)
    );

    // -------------------------------------------------------------------
    // Digit engine and final registers
    // -------------------------------------------------------------------
    logic [TEMP_W-1:0] temp_q;
    wire  [7:0]        top2     = temp_q[TEMP_W-1 -: 8];
    wire               load     = pop && head_is_addr;
    wire               load_fn  = load && head.d2 == SEL_MOD_FN;
    wire               load_pct = load && head.d2 == SEL_MOD_PCT;
    wire  [7:0]        fn_nx    = load_fn ? top2 : o_mod_function;
    wire  [7:0]        pct_nx   = load_pct ? top2 : o_mod_percent;
    wire  [9:0]        pct_bin  = 10'(pct_nx[7:4]) * 10'd10 + 10'(pct_nx[3:0]);

    mod_type_e type_nx;
    mod_src_e  src_nx;
    logic [9:0] depth_nx;
    always_comb begin
        case (fn_nx[7:4])
            TYPE_FM_X10: type_nx = MOD_FM_X10;
            TYPE_FM_X1:  type_nx = MOD_FM_X1;
            TYPE_FM_X01: type_nx = MOD_FM_X01;
            TYPE_AM:     type_nx = MOD_AM;
            default:     type_nx = MOD_OFF;
        endcase
        case (fn_nx[3:0])
            SRC_INT_1K:  src_nx = SRC_1K;
            SRC_INT_400: src_nx = SRC_400;
            SRC_EXT_DC:  src_nx = SRC_DC;
            SRC_EXT_AC:  src_nx = SRC_AC;
            default:     src_nx = SRC_NONE;
        endcase
        case (type_nx)
            MOD_FM_X10: depth_nx = 10'(pct_bin * 10'd10);
            MOD_FM_X01: depth_nx = pct_bin / 10'd10;
            default:    depth_nx = pct_bin;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            temp_q                    <= TEMP_RESET;
            o_temp_digits             <= TEMP_RESET;
            o_center_freq             <= TEMP_RESET;
            o_step_increment_register <= TEMP_RESET;
            o_attenuator              <= '0;
            o_mod_function            <= '0;
            o_mod_percent             <= '0;
            o_mod_enable              <= 1'b0;
            o_mod_type                <= MOD_OFF;
            o_mod_source              <= SRC_NONE;
            o_mod_depth               <= '0;
        end else if (i_clk_en) begin
            if (pop && !head_is_addr) begin
                temp_q        <= {head.d2, head.d1, temp_q[TEMP_W-1:8]};
                o_temp_digits <= {head.d2, head.d1, temp_q[TEMP_W-1:8]};
            end
            if (load) begin
                temp_q        <= TEMP_RESET;
                o_temp_digits <= TEMP_RESET;
                case (head.d2)
                    SEL_CENTER: o_center_freq             <= temp_q;
                    SEL_STEP:   o_step_increment_register <= temp_q;
                    SEL_ATTEN:  o_attenuator <= temp_q[TEMP_W-1 -: ATTEN_W];
                    default:    ;
                endcase
            end
            o_mod_function <= fn_nx;
            o_mod_percent  <= pct_nx;
            o_mod_enable   <= fn_nx != 8'h00 && type_nx != MOD_OFF;
            o_mod_type     <= type_nx;
            o_mod_source   <= src_nx;
            o_mod_depth    <= depth_nx;
        end
    end

    // -------------------------------------------------------------------
    // Constant and status outputs
    // -------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ready_for_byte_o       <= 1'b0;
            o_dac_o                  <= 1'b0;
            o_srq_oe                 <= 1'b0;
            o_eoi_oe                 <= 1'b0;
            o_listen                 <= 1'b0;
            o_local_remote_indicator <= 1'b0;
        end else if (i_clk_en) begin
            o_ready_for_byte_o       <= 1'b0;
            o_dac_o                  <= 1'b0;
            o_srq_oe                 <= 1'b0;
            o_eoi_oe                 <= 1'b0;
            o_listen                 <= listen_d;
            o_local_remote_indicator <= remote_q;
        end
    end
endmodule : remote_digit_programming_port

`default_nettype wire

// ==== core/rdp_pkg.sv ====
// Purpose: Shared constants and types of the remote digit programming port
// Assumes: Ground-true bus bytes are inverted before any compare
// Notes:   One bus byte carries two BCD digits, first digit in the high nibble
`default_nettype none
package rdp_pkg;
    // -------------------------------------------------------------------
    // Sizes
    // -------------------------------------------------------------------
    localparam int unsigned DIGITS       = 10;
    localparam int unsigned TEMP_W       = 4 * DIGITS;
    localparam int unsigned ATTEN_W      = 12;
    localparam int unsigned FIFO_WIDTH   = 8;
    localparam int unsigned FIFO_DEPTH   = 32;
    localparam int unsigned SYNC_W       = 13;
    // -------------------------------------------------------------------
    // Bus codes, after inversion of the ground-true lines
    // -------------------------------------------------------------------
    localparam logic [7:0] LISTEN_ADDR   = 8'h35;
    localparam logic [7:0] UNLISTEN_CMD  = 8'h3F;
    localparam logic [3:0] ADDR_MARK     = 4'hF;
    // -------------------------------------------------------------------
    // Final register select codes
    // -------------------------------------------------------------------
    localparam logic [3:0] SEL_CENTER    = 4'h0;
    localparam logic [3:0] SEL_STEP      = 4'h1;
    localparam logic [3:0] SEL_ATTEN     = 4'h3;
    localparam logic [3:0] SEL_MOD_FN    = 4'h4;
    localparam logic [3:0] SEL_MOD_PCT   = 4'h5;
    // -------------------------------------------------------------------
    // Modulation type and source digits
    // -------------------------------------------------------------------
    localparam logic [3:0] TYPE_OFF      = 4'h0;
    localparam logic [3:0] TYPE_FM_X10   = 4'h1;
    localparam logic [3:0] TYPE_FM_X1    = 4'h2;
    localparam logic [3:0] TYPE_FM_X01   = 4'h4;
    localparam logic [3:0] TYPE_AM       = 4'hC;
    localparam logic [3:0] SRC_INT_1K    = 4'h1;
    localparam logic [3:0] SRC_INT_400   = 4'h2;
    localparam logic [3:0] SRC_EXT_DC    = 4'h4;
    localparam logic [3:0] SRC_EXT_AC    = 4'h9;
    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [TEMP_W-1:0] TEMP_RESET = 40'h00_0000_0000;
    localparam logic [7:0]        BYTE_RESET = 8'h00;

    typedef enum logic [2:0] {MOD_OFF, MOD_FM_X10, MOD_FM_X1, MOD_FM_X01, MOD_AM} mod_type_e;
    typedef enum logic [2:0] {SRC_NONE, SRC_1K, SRC_400, SRC_DC, SRC_AC} mod_src_e;

    typedef struct packed {
        logic [3:0] d1;
        logic [3:0] d2;
    } entry_s;
endpackage : rdp_pkg
`default_nettype wire

// ==== dv/rdp_port_monitor.sv ====
// Purpose: Concurrent checks on the listener port outputs
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to every instance of the port
`timescale 1ns/1ns
`default_nettype none
module rdp_port_monitor
    import rdp_pkg::*;
(
    input wire logic              i_sys_clk,
    input wire logic              i_reset_n,
    input wire logic              i_dav_n,
    input wire logic              i_address_data_select,
    input wire logic              i_ren_n,
    input wire logic              i_bus_abort_line_n,
    input wire logic              i_rfd_delay_jumper,
    input wire logic              i_settle_busy,
    input wire logic              o_ready_for_byte_o,
    input wire logic              o_ready_for_byte_oe,
    input wire logic              o_dac_o,
    input wire logic              o_dac_oe,
    input wire logic              o_srq_oe,
    input wire logic              o_eoi_oe,
    input wire logic              o_listen,
    input wire logic              o_local_remote_indicator,
    input wire logic [TEMP_W-1:0] o_temp_digits,
    input wire logic [TEMP_W-1:0] o_step_increment_register,
    input wire logic [7:0]        o_mod_function,
    input wire logic              o_mod_enable,
    input wire mod_type_e         o_mod_type
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);

    sequence s_abort_held;  !i_bus_abort_line_n [*4]; endsequence
    sequence s_talker_idle; (i_dav_n && o_listen && i_bus_abort_line_n) [*5]; endsequence
    sequence s_settle_hold; (o_listen && !i_rfd_delay_jumper && i_settle_busy) [*4]; endsequence

    property p_unused_lines; !o_srq_oe && !o_eoi_oe && !o_ready_for_byte_o && !o_dac_o; endproperty
    a_unused_lines: assert property (p_unused_lines) else $error("unused line driven");
    property p_abort; s_abort_held |=> !o_listen && !o_ready_for_byte_oe && !o_dac_oe; endproperty
    a_abort: assert property (p_abort) else $error("abort not honoured");
    property p_dac_rearm; s_talker_idle |=> o_dac_oe; endproperty
    a_dac_rearm: assert property (p_dac_rearm) else $error("accept line not pulled low");
    property p_dac_ack; $rose(o_ready_for_byte_oe) && !i_dav_n |=> !o_dac_oe; endproperty
    a_dac_ack: assert property (p_dac_ack) else $error("accept not released");
    property p_rfd_hold;
        $fell(o_dac_oe) && o_listen && i_bus_abort_line_n |-> o_ready_for_byte_oe;
    endproperty
    a_rfd_hold: assert property (p_rfd_hold) else $error("ready released early");
    property p_settle; s_settle_hold |=> o_ready_for_byte_oe; endproperty
    a_settle: assert property (p_settle) else $error("ready released while settling");
    property p_remote_set; (o_listen && !i_ren_n) [*4] |=> o_local_remote_indicator; endproperty
    a_remote_set: assert property (p_remote_set) else $error("remote not entered");
    property p_remote_clr; i_ren_n [*4] |=> !o_local_remote_indicator; endproperty
    a_remote_clr: assert property (p_remote_clr) else $error("remote not left");
    property p_listen_keep;
        (o_listen && i_address_data_select && i_bus_abort_line_n) [*4] |=> o_listen;
    endproperty
    a_listen_keep: assert property (p_listen_keep) else $error("listen lost");
    property p_transfer;
        $changed(o_step_increment_register) |->
            o_temp_digits == '0 && o_step_increment_register == $past(o_temp_digits);
    endproperty
    a_transfer: assert property (p_transfer) else $error("bad transfer");
    property p_shift;
        $changed(o_temp_digits) && o_temp_digits != '0 |->
            {8'h00, o_temp_digits[TEMP_W-9:0]} == ($past(o_temp_digits) >> 8);
    endproperty
    a_shift: assert property (p_shift) else $error("bad digit shift");
    property p_mod_off; o_mod_function == 8'h00 |-> !o_mod_enable && o_mod_type == MOD_OFF; endproperty
    a_mod_off: assert property (p_mod_off) else $error("modulation not off");
endmodule : rdp_port_monitor

bind remote_digit_programming_port rdp_port_monitor u_rdp_port_monitor (
    .i_sys_clk, .i_reset_n, .i_dav_n, .i_address_data_select, .i_ren_n,
    .i_bus_abort_line_n, .i_rfd_delay_jumper, .i_settle_busy, .o_ready_for_byte_o,
    .o_ready_for_byte_oe, .o_dac_o, .o_dac_oe, .o_srq_oe, .o_eoi_oe, .o_listen,
    .o_local_remote_indicator, .o_temp_digits, .o_step_increment_register,
    .o_mod_function, .o_mod_enable, .o_mod_type
);
`default_nettype wire

// ==== dv/bus_controller_model.sv ====
// Purpose: Talker model for the eight-line bus
// Assumes: Open-drain handshake lines with pull-ups
// Notes:   Released data lines float to the pull-up level
`timescale 1ns/1ns
`default_nettype none
module bus_controller_model (
    // Clock and handshake lines
    input  wire logic  i_sys_clk,
    input  wire logic  i_rfd_line,
    input  wire logic  i_dac_line,
    // Driven lines
    output logic [7:0] o_bus_data_pin,
    output logic       o_dav_n,
    output logic       o_address_data_select
);
    bit hang = 1'b0;
    initial begin
        o_bus_data_pin = 8'hFF;
        o_dav_n = 1'b1;
        o_address_data_select = 1'b1;
    end
    task automatic wait_line(input logic sel);
        int n;
        n = 0;
        while ((sel ? i_dac_line : i_rfd_line) !== 1'b1 && n < 400) begin
            @(posedge i_sys_clk);
            #1;
            n++;
        end
        if (n >= 400) hang = 1'b1;
    endtask : wait_line
    task automatic send(input logic mode, input logic [7:0] value);
        wait_line(1'b0);
        o_address_data_select = mode;
        o_bus_data_pin = ~value;
        repeat (3) @(posedge i_sys_clk);
        #1 o_dav_n = 1'b0;
        @(posedge i_sys_clk);
        #1 wait_line(1'b1);
        o_dav_n = 1'b1;
        o_bus_data_pin = 8'hFF;
    endtask : send
endmodule : bus_controller_model
`default_nettype wire

// ==== dv/remote_digit_programming_port_tb.sv ====
// Purpose: Self-checking bench for the remote digit programming port
// Assumes: The controller model is the only talker
// Notes:   FIFO fill uses a stalled register transfer
`timescale 1ns/1ns
`default_nettype none
module remote_digit_programming_port_tb;
    import rdp_pkg::*;
    logic clk, rst_n, jumper, settle, load_rdy, ren_n, abort_n;
    logic [7:0] bus, fn, pct;
    logic dav_n, ads, rfd_o, rfd_oe, dac_o, dac_oe, listen, remote, mod_en;
    logic [39:0] temp, center, step;
    logic [11:0] atten;
    logic [9:0] depth;
    mod_type_e mod_type;
    mod_src_e mod_src;
    int fails = 0;
    int comparisons = 0;
    int cycles = 0;
    localparam logic [7:0] cf_bytes [6] = '{8'h12, 8'h34, 8'h56, 8'h70, 8'h10, 8'hF0};
    localparam logic [7:0] fn_byte [4] = '{8'h1C, 8'h21, 8'h42, 8'h94};
    localparam mod_type_e ty [4] = '{MOD_AM, MOD_FM_X10, MOD_FM_X1, MOD_FM_X01};
    localparam mod_src_e sr [4] = '{SRC_1K, SRC_400, SRC_DC, SRC_AC};
    localparam logic [9:0] dp [4] = '{10'h003, 10'h01E, 10'h003, 10'h000};
    wire rfd_line = rfd_oe ? rfd_o : 1'b1;
    wire dac_line = dac_oe ? dac_o : 1'b1;

    remote_digit_programming_port u_remote_digit_programming_port (
        .i_sys_clk(clk), .i_reset_n(rst_n), .i_clk_en(1'b1), .i_bus_data_pin(bus),
        .i_dav_n(dav_n), .i_address_data_select(ads), .i_ren_n(ren_n),
        .i_bus_abort_line_n(abort_n), .i_rfd_delay_jumper(jumper),
        .o_ready_for_byte_o(rfd_o), .o_ready_for_byte_oe(rfd_oe), .o_dac_o(dac_o),
        .o_dac_oe(dac_oe), .o_srq_oe(), .o_eoi_oe(), .i_settle_busy(settle),
        .i_load_ready(load_rdy), .o_listen(listen), .o_local_remote_indicator(remote),
        .o_temp_digits(temp), .o_center_freq(center), .o_step_increment_register(step),
        .o_attenuator(atten), .o_mod_function(fn), .o_mod_percent(pct),
        .o_mod_enable(mod_en), .o_mod_type(mod_type), .o_mod_source(mod_src),
        .o_mod_depth(depth)
    );
    bus_controller_model u_bus_controller_model (
        .i_sys_clk(clk), .i_rfd_line(rfd_line), .i_dac_line(dac_line),
        .o_bus_data_pin(bus), .o_dav_n(dav_n), .o_address_data_select(ads)
    );

    task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic test_done;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic xfer(input logic m, input logic [7:0] v);
        u_bus_controller_model.send(m, v);
        tick(4);
    endtask : xfer

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            test_done();
        end
    end

    initial begin
        {rst_n, settle, load_rdy, jumper, ren_n, abort_n} = 6'b001111;
        tick(8);
        rst_n = 1'b1;
        tick(3);
        chk("temp", temp, '0);
        chk("ready", rfd_oe, 1'b0);
        chk("type", mod_type, MOD_OFF);
        xfer(1'b1, 8'h12);
        chk("unaddressed temp", temp, '0);
        ren_n = 1'b0;
        xfer(1'b0, LISTEN_ADDR);
        chk("listen", listen, 1'b1);
        chk("remote", remote, 1'b1);
        xfer(1'b1, 8'h55);
        xfer(1'b1, 8'hF9);
        chk("false address", temp, '0);
        xfer(1'b1, 8'h01);
        chk("shift", temp, 40'h1000000000);
        xfer(1'b1, 8'h00);
        xfer(1'b1, 8'hF1);
        chk("step", step, 40'h0010000000);
        chk("cleared", temp, '0);
        xfer(1'b1, 8'h07);
        xfer(1'b1, 8'h00);
        xfer(1'b1, 8'hF3);
        chk("atten", atten, 12'h007);
        foreach (cf_bytes[i]) xfer(1'b1, cf_bytes[i]);
        chk("center", center, 40'h0107654321);
        xfer(1'b1, 8'h30);
        xfer(1'b1, 8'hF5);
        chk("percent", pct, 8'h03);
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, fn_byte[i]);
            xfer(1'b1, 8'hF4);
            chk("function", fn, {fn_byte[i][3:0], fn_byte[i][7:4]});
            chk("mod type", mod_type, ty[i]);
            chk("source", mod_src, sr[i]);
            chk("depth", depth, dp[i]);
            chk("enable", mod_en, 1'b1);
        end
        xfer(1'b1, 8'hF4);
        chk("off enable", mod_en, 1'b0);
        chk("off type", mod_type, MOD_OFF);
        {jumper, settle} = 2'b01;
        tick(6);
        chk("settling", rfd_oe, 1'b1);
        settle = 1'b0;
        tick(6);
        chk("settled", rfd_oe, 1'b0);
        jumper = 1'b1;
        xfer(1'b1, 8'h12);
        load_rdy = 1'b0;
        xfer(1'b1, 8'hF0);
        repeat (31) xfer(1'b1, 8'h00);
        tick(10);
        chk("full", rfd_oe, 1'b1);
        chk("stalled", center, 40'h0107654321);
        load_rdy = 1'b1;
        tick(80);
        chk("drained", center, 40'h2100000000);
        chk("drained temp", temp, '0);
        xfer(1'b0, UNLISTEN_CMD);
        chk("unlisten", listen, 1'b0);
        ren_n = 1'b1;
        tick(6);
        chk("local", remote, 1'b0);
        xfer(1'b0, LISTEN_ADDR);
        abort_n = 1'b0;
        tick(6);
        chk("abort listen", listen, 1'b0);
        chk("abort accept", dac_oe, 1'b0);
        abort_n = 1'b1;
        xfer(1'b0, LISTEN_ADDR);
        xfer(1'b1, 8'h55);
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(3);
        chk("reset temp", temp, '0);
        chk("reset step", step, '0);
        chk("reset listen", listen, 1'b0);
        chk("talker", u_bus_controller_model.hang, 1'b0);
        test_done();
    end
endmodule : remote_digit_programming_port_tb
`default_nettype wire
